// ==== src/wkst_wake_status.sv ====
// Wake event status, enable and wake request logic with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "wkst_params.svh"

module wkst_wake_status (
  // Clock and standby power-on reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Wake sources from pins
  input  wire wkst_pkg::wkst_src_t wake_src,
  // Wake request to power management and interrupt request
  output logic                    wake_request_out_n,
  output logic                    irq,
  // AXI4-Lite write address
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [7:0]         awaddr,
  input  wire logic [2:0]         awprot,
  // AXI4-Lite write data
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  // AXI4-Lite write response
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  // AXI4-Lite read address
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [7:0]         araddr,
  input  wire logic [2:0]         arprot,
  // AXI4-Lite read data
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp
);
  import wkst_pkg::*;

  wkst_state_t st_reg;
  wkst_state_t st_next;
  wkst_src_t   set_bits;
  wkst_src_t   clr_bits;
  logic [1:0]  irq_events;
  logic        irq_rd_clr;
  logic [5:0]  w_idx;
  logic [5:0]  r_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake outputs

  assign awready            = !st_reg.aw_full;
  assign wready             = !st_reg.w_full;
  assign arready            = !st_reg.rvalid;
  assign bvalid             = st_reg.bvalid;
  assign bresp              = st_reg.bresp;
  assign rvalid             = st_reg.rvalid;
  assign rdata              = {24'h000000, st_reg.rdata};
  assign rresp              = st_reg.rresp;
  assign wake_request_out_n = !st_reg.wake_active;
  assign irq                = |(st_reg.irq_status & st_reg.irq_mask);
  assign w_idx              = st_reg.aw_addr[7:2];
  assign r_idx              = araddr[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next    = st_reg;
    clr_bits   = '0;
    irq_rd_clr = 1'b0;

    // Two-stage synchroniser on the pins
    st_next.sync1 = wake_src;
    st_next.sync2 = st_reg.sync1;

    // Address and data may arrive in either order
    if (awvalid && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.w_data = wdata[7:0];
      st_next.w_lane = wstrb[0];
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end

    // Commit once both halves are held and the previous response is gone
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `WKST_RESP_OKAY;
      unique case (w_idx)
        `WKST_IDX_STATUS_ONE: begin
          if (st_reg.w_lane) clr_bits.group_one = st_reg.w_data;
        end
        `WKST_IDX_STATUS_FOUR: begin
          if (st_reg.w_lane) clr_bits.group_four = st_reg.w_data;
        end
        `WKST_IDX_STATUS_FIVE: begin
          if (st_reg.w_lane) clr_bits.group_five = st_reg.w_data;
        end
        `WKST_IDX_RESERVED: begin
          // Read-only slot, write accepted and dropped
        end
        `WKST_IDX_ENABLE_ONE: begin
          if (st_reg.w_lane) st_next.enable_one = st_reg.w_data;
        end
        `WKST_IDX_CONTROL: begin
          if (st_reg.w_lane) st_next.global_en = st_reg.w_data[`WKST_CTRL_GLOBAL_BIT];
        end
        `WKST_IDX_IRQ_STATUS: begin
          // Cleared by reading, writes have no effect
        end
        `WKST_IDX_IRQ_MASK: begin
          if (st_reg.w_lane) st_next.irq_mask = st_reg.w_data[1:0];
        end
        default: begin
          st_next.bresp = `WKST_RESP_SLVERR;
        end
      endcase
    end

    // Read side
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `WKST_RESP_OKAY;
      st_next.rdata  = 8'h00;
      unique case (r_idx)
        `WKST_IDX_STATUS_ONE:  st_next.rdata = st_reg.status.group_one;
        `WKST_IDX_STATUS_FOUR: st_next.rdata = st_reg.status.group_four;
        `WKST_IDX_STATUS_FIVE: st_next.rdata = st_reg.status.group_five;
        `WKST_IDX_RESERVED:    st_next.rdata = 8'h00;
        `WKST_IDX_ENABLE_ONE:  st_next.rdata = st_reg.enable_one;
        `WKST_IDX_CONTROL:     st_next.rdata = {7'h00, st_reg.global_en};
        `WKST_IDX_IRQ_STATUS: begin
          st_next.rdata = {6'h00, st_reg.irq_status};
          irq_rd_clr    = 1'b1;
        end
        `WKST_IDX_IRQ_MASK:    st_next.rdata = {6'h00, st_reg.irq_mask};
        default: begin
          st_next.rresp = `WKST_RESP_SLVERR;
        end
      endcase
    end

    // Sticky status; a source still high re-sets in the same cycle as a clear
    set_bits       = st_reg.sync2;
    st_next.status = (st_reg.status & ~clr_bits) | set_bits;

    // Only group one sources have enables here
    st_next.wake_active = st_reg.global_en && |(st_reg.status.group_one & st_reg.enable_one);

    irq_events[`WKST_IRQ_NEW_BIT]  = |(set_bits & ~st_reg.status);
    irq_events[`WKST_IRQ_WAKE_BIT] = st_next.wake_active && !st_reg.wake_active;
    st_next.irq_status = (irq_rd_clr ? `WKST_RESET_IRQ : st_reg.irq_status) | irq_events;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; aresetn is the standby power-on reset only

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg                  <= '0;
      st_reg.status           <= '{`WKST_RESET_BYTE, `WKST_RESET_BYTE, `WKST_RESET_BYTE};
      st_reg.enable_one       <= `WKST_RESET_BYTE;
      st_reg.irq_status       <= `WKST_RESET_IRQ;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ==== src/wkst_params.svh ====
// Register indices, field positions, reset values and bus codes for the wake status block
//
// Overview of operation
// - Every wake status bit follows its own source, regardless of the source enable or global enable.
// - A wake event from a source sets that source's status bit to one.
// - Status four bits 0-3 are pins 30-33, bit 4 pin 41, bit 5 pin 43, bit 6 pin 60, bit 7 pin 61.
// - Status five bits 0-7 are pins 50-57 in order.
// - Writing one to a status bit clears it and writing zero leaves it alone.
// - Status registers clear to zero only on the standby power-on reset.
// - The location after status five is reserved, read-only, and reads zero.
// - The wake request output goes low when a source's enable, its status and the global enable are all one.
// - A source with its enable at zero still updates its status but never requests wake.
// - Enable one bits are infrared, ring two, ring one, keyboard, mouse, specific key, fan one, fan two.
// - Enable one clears to zero only on the standby power-on reset.
// - The enable bits choose which sources drive the shared wake request, and software reads and writes all eight.
`ifndef WKST_PARAMS_SVH
`define WKST_PARAMS_SVH

// Register indices; byte address is four times the index
`define WKST_IDX_STATUS_ONE  6'h04
`define WKST_IDX_STATUS_FOUR 6'h07
`define WKST_IDX_STATUS_FIVE 6'h08
`define WKST_IDX_RESERVED    6'h09
`define WKST_IDX_ENABLE_ONE  6'h0A
`define WKST_IDX_CONTROL     6'h10
`define WKST_IDX_IRQ_STATUS  6'h11
`define WKST_IDX_IRQ_MASK    6'h12

// Field positions
`define WKST_CTRL_GLOBAL_BIT 0
`define WKST_IRQ_NEW_BIT     0
`define WKST_IRQ_WAKE_BIT    1

// Reset values
`define WKST_RESET_BYTE      8'h00
`define WKST_RESET_IRQ       2'h0

// Bus answers
`define WKST_RESP_OKAY       2'h0
`define WKST_RESP_SLVERR     2'h2

`endif

// ==== src/wkst_pkg.sv ====
// Types shared by the wake status block
package wkst_pkg;

  typedef struct packed {
    logic [7:0] group_one;
    logic [7:0] group_four;
    logic [7:0] group_five;
  } wkst_src_t;

  typedef struct packed {
    wkst_src_t  sync1;
    wkst_src_t  sync2;
    wkst_src_t  status;
    logic [7:0] enable_one;
    logic       global_en;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       wake_active;
    logic       aw_full;
    logic [7:0] aw_addr;
    logic       w_full;
    logic [7:0] w_data;
    logic       w_lane;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } wkst_state_t;

endpackage

// ==== verification/wkst_wake_status_assertions.sv ====
// Port checks for the wake status block
`timescale 1ns/100ps
module wkst_wake_status_assertions (
  // Clock, reset and wake line
  input wire logic        aclk, aresetn, wake_request_out_n,
  // Register bus
  input wire logic        awvalid, awready, wvalid, wready, bvalid,
  input wire logic        arvalid, arready, rvalid, rready,
  input wire logic [7:0]  araddr,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  logic [7:0] ra_reg;
  always_ff @(posedge aclk) if (arvalid && arready) ra_reg <= araddr;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd; arvalid && arready; endsequence
  property p_idle; $rose(aresetn) |-> wake_request_out_n; endproperty
  a_idle: assert property (p_idle) else $error("wake low after reset");
  // Status is sticky, so only a write commit can end a request
  property p_hold; !wake_request_out_n && !bvalid |=> !wake_request_out_n; endproperty
  a_hold: assert property (p_hold) else $error("wake dropped without write");
  property p_rsvd; rvalid && ra_reg[7:2] == 6'h09 |-> rdata == 32'h0 && rresp == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_hi; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_w_ans; s_wr ##1 !bvalid |=> bvalid; endproperty
  a_w_ans: assert property (p_w_ans) else $error("write answer late");
  property p_w_ref; s_wr |=> !awready && !wready; endproperty
  a_w_ref: assert property (p_w_ref) else $error("write not refused");
  property p_r_ans; s_rd |=> rvalid && !arready; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_end; rvalid && rready |=> !rvalid; endproperty
  a_r_end: assert property (p_r_end) else $error("read data stuck");
endmodule
bind wkst_wake_status wkst_wake_status_assertions chk (.*);

// ==== verification/wkst_pm_model.sv ====
// Power management side model: counts wake requests
`timescale 1ns/100ps
module wkst_pm_model (
  // Clock and wake line
  input wire logic   aclk, wake_request_out_n,
  // Wake requests seen
  output logic [7:0] wake_count
);
  logic       last_reg  = 1'b1;
  logic [7:0] count_reg = 8'h00;
  // One process owns the count, the port only mirrors it
  assign wake_count = count_reg;
  always @(posedge aclk) begin
    last_reg <= wake_request_out_n;
    if (last_reg && !wake_request_out_n) count_reg <= count_reg + 8'h01;
  end
endmodule

// ==== verification/tb_wake_event_status_enable.sv ====
// Register level test bench for the wake status block
`timescale 1ns/100ps
`include "wkst_params.svh"
module tb_wake_event_status_enable;
  import wkst_pkg::*;
  logic        aclk = 1'b0, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, wake_request_out_n;
  logic [7:0]  awaddr, araddr, wake_count, v;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [3:0]  wstrb = 4'hF;
  wkst_src_t   wake_src;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  localparam logic [7:0] st1 = 8'h10, st4 = 8'h1C, st5 = 8'h20, rsv = 8'h24;
  localparam logic [7:0] en1 = 8'h28, ctl = 8'h40, ist = 8'h44, msk = 8'h48;
  wkst_wake_status dut (.*);
  wkst_pm_model    pm (.*);
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) n_errors++;
    if (cyc == 4000) complete_run();
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) bs = bresp;
      if (bvalid) bready <= 1'b0;
    end while (bready);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d  = rdata[7:0];
    rs = rresp;
  endtask
  // Holds the level past the two stage synchroniser
  task automatic pulse(input wkst_src_t s);
    wake_src <= s;
    repeat (4) @(posedge aclk);
    wake_src <= '0;
    repeat (4) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wake_src = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(st4 + 8'(4 * i), v);
      chk("reset value", 8'h00, v);
    end
    wr(rsv, 8'hFF);
    chk("reserved write resp", 8'(`WKST_RESP_OKAY), 8'(bs));
    wr(8'hFC, 8'hFF);
    chk("unmapped write resp", 8'(`WKST_RESP_SLVERR), 8'(bs));
    rd(rsv, v);
    chk("reserved", 8'h00, v);
    rd(8'hFC, v);
    chk("unmapped resp", 8'(`WKST_RESP_SLVERR), 8'(rs));
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pulse({8'h00, 8'(1 << i), 8'(8'h80 >> i)});
      rd(st4, v);
      chk("status four", 8'(1 << i), v);
      rd(st5, v);
      chk("status five", 8'(8'h80 >> i), v);
      wr(st5, ~v);
      rd(st5, v);
      chk("status kept", 8'(8'h80 >> i), v);
      wr(st4, 8'(1 << i));
      rd(st4, v);
      chk("status clear", 8'h00, v);
      wr(st5, 8'(8'h80 >> i));
      rd(st5, v);
      chk("status five clear", 8'h00, v);
    end
    wr(st5, 8'hFF);
    $display("test status done");
    wr(en1, 8'hA5);
    rd(en1, v);
    chk("enable", 8'hA5, v);
    wr(ctl, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(en1, ~8'(1 << i));
      pulse({8'(1 << i), 16'h0});
      chk("wake off", 8'h01, 8'(wake_request_out_n));
      rd(st1, v);
      chk("status one", 8'(1 << i), v);
      wr(en1, 8'(1 << i));
      repeat (2) @(posedge aclk);
      chk("wake on", 8'h00, 8'(wake_request_out_n));
      wr(st1, 8'hFF);
      repeat (2) @(posedge aclk);
      chk("wake clear", 8'h01, 8'(wake_request_out_n));
    end
    chk("wake count", 8'h08, wake_count);
    wr(ctl, 8'h00);
    wr(en1, 8'hFF);
    pulse({8'h01, 16'h0});
    chk("global off", 8'h01, 8'(wake_request_out_n));
    $display("test wake done");
    wr(msk, 8'h01);
    rd(ist, v);
    chk("irq status", 8'h03, v);
    @(posedge aclk);
    chk("irq read", 8'h00, 8'(irq));
    wr(msk, 8'h00);
    pulse({16'h0, 8'h01});
    chk("irq masked", 8'h00, 8'(irq));
    wr(msk, 8'h01);
    chk("irq unmasked", 8'h01, 8'(irq));
    $display("test irq done");
    complete_run();
  end
endmodule
